// *** verilog/adc_readout_pkg.sv ***
// shared constants for the converter readout link and both of its ends
package adc_readout_pkg;
  // ====================================================================
  // result format
  localparam int RESULT_BITS = 24;
  localparam logic [23:0] RESULT_RESET = 24'h000000;
  localparam logic [23:0] RESULT_NEG_FULL = 24'h800000;
  // ====================================================================
  // decimation
  localparam int MOD_DIV = 6;
  localparam int OSR = 64;
  localparam int FILTER_ORDER = 5;
  localparam int SETTLE_SAMPLES = FILTER_ORDER * OSR;
  localparam int SETTLE_CLKS = SETTLE_SAMPLES * MOD_DIV;
  localparam int SETTLE_PERIODS = FILTER_ORDER + 1;
  // ====================================================================
  // conversion period partitioning, in system clocks
  localparam int PERIOD_CLKS = 384;
  localparam int READY_CLKS = 36;
  localparam int SHIFT_CLKS = PERIOD_CLKS - READY_CLKS;
  localparam int WRITE_CLKS = 6;
  localparam int LOW_CLKS = 6;
  localparam int PRE_DATA_CLKS = 6;
  localparam int PRE_READY_CLKS = 24;
  localparam int WRITE_START = 0;
  localparam int LOW_START = WRITE_START + WRITE_CLKS;
  localparam int PRE_DATA_START = LOW_START + LOW_CLKS;
  localparam int SHIFT_START = PRE_DATA_START + PRE_DATA_CLKS;
  localparam int PRE_READY_START = PERIOD_CLKS - PRE_READY_CLKS;
  // ====================================================================
  // synchronisation
  localparam int SYNC_HOLD_PERIODS = 4;
  localparam int SYNC_SAFE_PERIODS = 5;
  localparam int SYNC_PULSE_CLKS = 3;
  // first shift clock delay after the ready phase ends
  localparam int FIRST_SHIFT_NS = 30;
  localparam int CLK_NS = 50;
  localparam int FIRST_SHIFT_CLKS =
    ((FIRST_SHIFT_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
    ((FIRST_SHIFT_NS + CLK_NS - 1) / CLK_NS);
  localparam int HOST_HALF_CLKS = 2;
  localparam int HOST_SYNC_PERIODS = 6;
endpackage

// *** verilog/adc_readout_if.sv ***
// link between converter readout end and host end
`timescale 1ns/1ps
interface adc_readout_if;
  logic serial_clk;
  logic shared_ready_data_pin;
  modport device (input serial_clk, output shared_ready_data_pin);
  modport host (output serial_clk, input shared_ready_data_pin);
endinterface

// *** verilog/adc_sinc_filter.sv ***
// fifth order cascade of 64-tap moving averages, one result per 64 samples
`timescale 1ns/1ps
module adc_sinc_filter #(
  parameter int ORDER = 5,
  parameter int RATIO = 64,
  parameter int OUT_BITS = 24
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // modulator side
  input wire logic i_restart,
  input wire logic i_sample_en,
  input wire logic i_sample_bit,
  // result side
  output logic o_result_en,
  output logic [OUT_BITS-1:0] o_result
);
  // integrator/comb width: 2 + order*log2(ratio) bits; the extra bit keeps
  // positive and negative full scale apart, as the gain reaches both ends
  localparam int W = 2 + ORDER * $clog2(RATIO);
  localparam int CW = $clog2(RATIO);
  logic [W-1:0] integ_reg [ORDER];
  logic [W-1:0] comb_dly_reg [ORDER];
  logic [W-1:0] comb_in [ORDER+1];
  logic [W-1:0] comb_out;
  logic pos_full;
  logic [OUT_BITS-1:0] scaled;
  logic [CW-1:0] dec_cnt_reg;
  logic dec_wrap;
  logic [W-1:0] input_val;
  logic result_en_reg;
  logic [OUT_BITS-1:0] result_reg;

  // modulator bit mapped to +1/-1, integrators accumulate per sample
  assign input_val = i_sample_bit ? W'(1) : {W{1'b1}};
  assign dec_wrap = (dec_cnt_reg == CW'(RATIO - 1));
  assign comb_in[0] = integ_reg[ORDER-1];
  // drop the gain of 64 per stage; positive full scale clips to the top code
  assign comb_out = comb_in[ORDER];
  assign pos_full = !comb_out[W-1] && comb_out[W-2];
  assign scaled = pos_full ? {1'b0, {(OUT_BITS-1){1'b1}}} : comb_out[W-2 -: OUT_BITS];

  genvar g;
  generate
    for (g = 0; g < ORDER; g++) begin : g_stage
      // integrator stage
      always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
          integ_reg[g] <= '0;
        end else if (i_ce && i_restart) begin
          integ_reg[g] <= '0;
        end else if (i_ce && i_sample_en) begin
          integ_reg[g] <= integ_reg[g] + ((g == 0) ? input_val : integ_reg[g-((g>0)?1:0)]);
        end
      end
      // comb stage at decimated rate, unpipelined: a register per stage would
      // add a period of latency each and break the settling count
      assign comb_in[g+1] = comb_in[g] - comb_dly_reg[g];
      always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
          comb_dly_reg[g] <= '0;
        end else if (i_ce && i_restart) begin
          comb_dly_reg[g] <= '0;
        end else if (i_ce && i_sample_en && dec_wrap) begin
          comb_dly_reg[g] <= comb_in[g];
        end
      end
    end
  endgenerate

  // decimation counter and output; each stage gain of 64 drops via the shift
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dec_cnt_reg <= '0;
      result_en_reg <= 1'b0;
      result_reg <= '0;
    end else if (i_ce) begin
      result_en_reg <= 1'b0;
      if (i_restart) begin
        dec_cnt_reg <= '0;
      end else if (i_sample_en) begin
        dec_cnt_reg <= dec_cnt_reg + CW'(1);
        if (dec_wrap) begin
          result_en_reg <= 1'b1;
          result_reg <= scaled;
        end
      end
    end
  end
  assign o_result_en = result_en_reg;
  assign o_result = result_reg;
endmodule

// *** verilog/adc_readout_device.sv ***
// converter end: modulator timing, filter, result register and shared pin
`timescale 1ns/1ps
module adc_readout_device (
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // modulator bitstream, one bit per modulator sample
  input wire logic i_mod_bit,
  // link
  adc_readout_if.device link,
  // status
  output logic o_mod_in_reset,
  output logic o_result_valid
);
  import adc_readout_pkg::*;

  typedef enum logic [1:0] {
    RUN = 2'b00,
    SYNC_PULSE = 2'b01,
    SYNC_HOLD = 2'b10
  } sync_state_e;

  sync_state_e sync_state_reg, sync_state_next;
  logic [8:0] period_cnt_reg;
  logic [2:0] mod_div_reg;
  logic [2:0] settle_cnt_reg;
  logic [2:0] high_periods_reg;
  logic high_whole_reg;
  logic [1:0] pulse_cnt_reg;
  logic sclk_d_reg;
  logic [23:0] dor_reg;
  logic [4:0] bit_ptr_reg;
  logic pin_reg;
  logic valid_reg;
  logic [23:0] filt_result;
  logic filt_result_en;

  // decode of period position
  wire period_end = (period_cnt_reg == 9'(PERIOD_CLKS - 1));
  wire in_write = (period_cnt_reg < 9'(LOW_START));
  wire in_low = (period_cnt_reg >= 9'(LOW_START)) && (period_cnt_reg < 9'(PRE_DATA_START));
  wire in_pre_data = (period_cnt_reg >= 9'(PRE_DATA_START)) &&
                     (period_cnt_reg < 9'(SHIFT_START));
  wire in_pre_ready = (period_cnt_reg >= 9'(PRE_READY_START));
  wire write_start = (period_cnt_reg == 9'(WRITE_START));
  wire pre_ready_start = (period_cnt_reg == 9'(PRE_READY_START));
  wire sclk_fall = sclk_d_reg && !link.serial_clk;
  wire running = (sync_state_reg == RUN);
  wire mod_tick = running && (mod_div_reg == 3'(MOD_DIV - 1));
  wire settled = (settle_cnt_reg == 3'(SETTLE_PERIODS - 1));
  wire release_sync = (sync_state_reg != RUN) && sclk_fall;
  wire pulse_done = (pulse_cnt_reg == 2'(SYNC_PULSE_CLKS - 1));
  wire sync_detect = running && period_end && high_whole_reg && link.serial_clk &&
                     (high_periods_reg == 3'(SYNC_HOLD_PERIODS - 1));
  wire shift_bit = (bit_ptr_reg < 5'(RESULT_BITS)) ? dor_reg[5'(RESULT_BITS - 1) - bit_ptr_reg]
                                                  : 1'b0;

  // decimation filter fed at the modulator rate
  adc_sinc_filter #(
    .ORDER(FILTER_ORDER),
    .RATIO(OSR),
    .OUT_BITS(RESULT_BITS)
  ) u_filter (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_restart(!running),
    .i_sample_en(mod_tick),
    .i_sample_bit(i_mod_bit),
    .o_result_en(filt_result_en),
    .o_result(filt_result)
  );

  // synchronisation state machine
  always_comb begin
    sync_state_next = sync_state_reg;
    case (sync_state_reg)
      RUN: if (sync_detect) sync_state_next = SYNC_PULSE;
      SYNC_PULSE: begin
        if (release_sync) sync_state_next = RUN;
        else if (pulse_done) sync_state_next = SYNC_HOLD;
      end
      SYNC_HOLD: if (release_sync) sync_state_next = RUN;
      default: sync_state_next = RUN;
    endcase
  end

  // modulator divider and period counter; both restart on release
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_state_reg <= RUN;
      mod_div_reg <= '0;
      period_cnt_reg <= '0;
      pulse_cnt_reg <= '0;
      sclk_d_reg <= 1'b0;
    end else if (i_ce) begin
      sync_state_reg <= sync_state_next;
      sclk_d_reg <= link.serial_clk;
      pulse_cnt_reg <= (sync_state_reg == SYNC_PULSE) ? pulse_cnt_reg + 2'd1 : 2'd0;
      mod_div_reg <= (!running || mod_div_reg == 3'(MOD_DIV - 1)) ? 3'd0 : mod_div_reg + 3'd1;
      period_cnt_reg <= (!running || period_end) ? 9'd0 : period_cnt_reg + 9'd1;
    end
  end

  // count whole periods with the serial clock held high
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      high_whole_reg <= 1'b0;
      high_periods_reg <= '0;
    end else if (i_ce) begin
      if (!running || period_end) begin
        high_whole_reg <= 1'b1;
        if (!running || !(high_whole_reg && link.serial_clk)) begin
          high_periods_reg <= '0;
        end else if (high_periods_reg != 3'(SYNC_HOLD_PERIODS - 1)) begin
          high_periods_reg <= high_periods_reg + 3'd1;
        end
      end else if (!link.serial_clk) begin
        high_whole_reg <= 1'b0;
      end
    end
  end

  // settling: ready pulses suppressed until six full periods after restart
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      settle_cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else if (i_ce) begin
      if (!running) begin
        settle_cnt_reg <= '0;
        valid_reg <= 1'b0;
      end else if (period_end) begin
        if (!settled) settle_cnt_reg <= settle_cnt_reg + 3'd1;
        valid_reg <= settled;
      end
    end
  end

  // result register loaded in the write interval; pointer reset at write and pre-ready
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dor_reg <= RESULT_RESET;
      bit_ptr_reg <= '0;
    end else if (i_ce) begin
      if (running && write_start) begin
        dor_reg <= filt_result;
      end
      if (write_start || pre_ready_start || !running) begin
        bit_ptr_reg <= '0;
      end else if (!in_write && !in_low && !in_pre_data && !in_pre_ready && sclk_fall &&
                   bit_ptr_reg != 5'(RESULT_BITS)) begin
        bit_ptr_reg <= bit_ptr_reg + 5'd1;
      end
    end
  end

  // shared pin drive, one flip-flop
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_reg <= 1'b1;
    end else if (i_ce) begin
      if (sync_state_next == SYNC_PULSE) pin_reg <= 1'b0;
      else if (!running) pin_reg <= 1'b1;
      else if (in_pre_ready || period_end) pin_reg <= 1'b1;
      else if (in_write) pin_reg <= 1'b1;
      else if (in_low) pin_reg <= !valid_reg;
      else if (in_pre_data) pin_reg <= 1'b1;
      else pin_reg <= shift_bit;
    end
  end

  assign link.shared_ready_data_pin = pin_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mod_in_reset <= 1'b0;
      o_result_valid <= 1'b0;
    end else if (i_ce) begin
      o_mod_in_reset <= (sync_state_next != RUN);
      o_result_valid <= valid_reg;
    end
  end
endmodule

// *** verilog/adc_readout_host.sv ***
// host end: detects ready, clocks out 24 bits, can request synchronisation
`timescale 1ns/1ps
module adc_readout_host (
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // user side
  input wire logic i_sync_req,
  output logic o_data_valid,
  output logic [23:0] o_data,
  output logic o_sync_busy,
  // link
  adc_readout_if.host link
);
  import adc_readout_pkg::*;

  typedef enum logic [2:0] {
    IDLE = 3'b000,
    WAIT_HIGH = 3'b001,
    WAIT_SHIFT = 3'b010,
    CLK_HIGH = 3'b011,
    CLK_LOW = 3'b100,
    SYNC = 3'b101,
    LOW_WAIT = 3'b110
  } host_state_e;

  host_state_e state_reg;
  logic [11:0] cnt_reg;
  logic [4:0] bits_reg;
  logic [23:0] shift_reg;
  logic sclk_reg;
  logic pin_d_reg;
  logic valid_reg;
  logic [5:0] high_run_reg;

  // a ready pulse is a low run of six after thirty high clocks; any other
  // falling edge is a data bit or a sync pulse and would start a bogus read
  wire ready_fall = pin_d_reg && !link.shared_ready_data_pin &&
                    (high_run_reg >= 6'(WRITE_CLKS + PRE_READY_CLKS));
  wire ready_rise = !pin_d_reg && link.shared_ready_data_pin;
  wire sync_done = (cnt_reg == 12'(HOST_SYNC_PERIODS * PERIOD_CLKS - 1));

  // host sequencer; waits out the pre-data high interval plus delay
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= IDLE;
      cnt_reg <= '0;
      bits_reg <= '0;
      shift_reg <= '0;
      sclk_reg <= 1'b0;
      pin_d_reg <= 1'b1;
      valid_reg <= 1'b0;
      high_run_reg <= '0;
    end else if (i_ce) begin
      pin_d_reg <= link.shared_ready_data_pin;
      high_run_reg <= link.shared_ready_data_pin ? high_run_reg + {5'h0, ~&high_run_reg} : 6'h00;
      valid_reg <= 1'b0;
      cnt_reg <= cnt_reg + 12'd1;
      case (state_reg)
        IDLE: begin
          if (i_sync_req) begin
            state_reg <= SYNC;
            sclk_reg <= 1'b1;
            cnt_reg <= '0;
          end else if (ready_fall) begin
            state_reg <= LOW_WAIT;
            cnt_reg <= '0;
          end
        end
        LOW_WAIT: begin
          if (ready_rise) begin
            state_reg <= (cnt_reg == 12'(LOW_CLKS - 1)) ? WAIT_HIGH : IDLE;
            cnt_reg <= '0;
          end else if (cnt_reg == 12'(LOW_CLKS)) begin
            state_reg <= IDLE;
          end
        end
        WAIT_HIGH: begin
          if (cnt_reg == 12'(PRE_DATA_CLKS + FIRST_SHIFT_CLKS - 1)) begin
            state_reg <= CLK_HIGH;
            bits_reg <= '0;
            cnt_reg <= '0;
            sclk_reg <= 1'b1;
          end
        end
        CLK_HIGH: begin
          if (cnt_reg == 12'(HOST_HALF_CLKS - 1)) begin
            shift_reg <= {shift_reg[22:0], link.shared_ready_data_pin};
            sclk_reg <= 1'b0;
            state_reg <= CLK_LOW;
            cnt_reg <= '0;
          end
        end
        CLK_LOW: begin
          if (cnt_reg == 12'(HOST_HALF_CLKS - 1)) begin
            cnt_reg <= '0;
            if (bits_reg == 5'(RESULT_BITS - 1)) begin
              valid_reg <= 1'b1;
              state_reg <= IDLE;
            end else begin
              bits_reg <= bits_reg + 5'd1;
              sclk_reg <= 1'b1;
              state_reg <= CLK_HIGH;
            end
          end
        end
        SYNC: begin
          if (sync_done) begin
            sclk_reg <= 1'b0;
            state_reg <= IDLE;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  assign link.serial_clk = sclk_reg;
  assign o_data_valid = valid_reg;
  assign o_data = shift_reg;
  assign o_sync_busy = (state_reg == SYNC);
endmodule

// *** test/adc_readout_chk.sv ***
// concurrent checks on the link between the converter end and the host end
`timescale 1ns/1ps
module adc_readout_chk (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // link
  input wire logic i_serial_clk,
  input wire logic i_shared_ready_data_pin
);
  // short local names for the two link lines
  wire serial_clk = i_serial_clk;
  wire shared_ready_data_pin = i_shared_ready_data_pin;
  // ==========================================================
  // run lengths seen up to the previous sample
  logic pin_q;
  logic sclk_q;
  logic sync_seen;
  logic [15:0] pin_run;
  logic [15:0] sclk_run;
  logic [15:0] since_rdy;
  logic [15:0] rel_cnt;
  logic [4:0] rises;
  // a ready pulse is only told apart from data bits by a long idle serial clock
  wire quiet = !serial_clk && !sclk_q && sclk_run > 16'h0028;
  wire rdy_end = shared_ready_data_pin && !pin_q && pin_run == 16'h0006 && quiet;
  wire held = serial_clk && sclk_q && sclk_run > 16'h0008;
  wire rel_start = !serial_clk && sclk_q && sclk_run > 16'h0008;
  wire rdy_short = shared_ready_data_pin && !pin_q && pin_run == 16'h0003;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // saturating run counters, pin starts high and clock low out of reset
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_q <= 1'b1;
      sclk_q <= 1'b0;
      pin_run <= 16'h0000;
      sclk_run <= 16'h0000;
    end else begin
      pin_q <= shared_ready_data_pin;
      sclk_q <= serial_clk;
      pin_run <= (shared_ready_data_pin != pin_q) ? 16'h0001 : pin_run + {15'h0, ~&pin_run};
      sclk_run <= (serial_clk != sclk_q) ? 16'h0001 : sclk_run + {15'h0, ~&sclk_run};
    end
  end
  // bit count per word, time since ready and since a sync release
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_seen <= 1'b0;
      since_rdy <= 16'hffff;
      rel_cnt <= 16'h0000;
      rises <= 5'h18;
    end else begin
      sync_seen <= serial_clk && (sync_seen || (held && rdy_short));
      since_rdy <= rdy_end ? 16'h0001 : since_rdy + {15'h0, ~&since_rdy};
      rises <= held ? 5'h18 : rdy_end ? 5'h00 : rises + {4'h0, serial_clk && !sclk_q};
      rel_cnt <= rel_start ? 16'h0001 : rdy_end ? 16'h0000 : rel_cnt + {15'h0, |rel_cnt};
    end
  end
  // ==========================================================
  // assertions
  chk_ready_low_len: assert property (shared_ready_data_pin && !pin_q && quiet |->
    pin_run == 16'h0006 || pin_run > 16'h0028) else $error("ready low pulse length wrong");
  chk_pre_data_high: assert property (rdy_end |-> shared_ready_data_pin [*6])
    else $error("pin not high before data");
  chk_pre_ready_high: assert property (rdy_end |-> $past(pin_run, 6) >= 16'h001e)
    else $error("pin not high long enough before ready");
  chk_shift_on_fall: assert property (serial_clk && sclk_q && sclk_run < 16'h0008 |->
    $stable(shared_ready_data_pin)) else $error("pin moved while serial clock high");
  chk_clock_window: assert property (serial_clk && !sclk_q && rises < 5'h18 |->
    since_rdy >= 16'h0007 && since_rdy < 16'h0150) else $error("serial clock out of window");
  chk_full_read: assert property (rdy_end |-> rises == 5'h18)
    else $error("word not fully clocked out");
  chk_sync_pulse: assert property (shared_ready_data_pin && !pin_q && held |->
    pin_run == 16'h0006 || pin_run > 16'h0028 ||
    (pin_run == 16'h0003 && sclk_run >= 16'h0603 && sclk_run < 16'h0790))
    else $error("sync pulse wrong");
  chk_sync_happens: assert property (held && sclk_run == 16'h0790 |-> sync_seen)
    else $error("no sync pulse after hold");
  chk_sync_hold_high: assert property (sync_seen |-> shared_ready_data_pin)
    else $error("pin not held high in sync");
  chk_hold_length: assert property (rel_start |->
    sclk_run >= 16'h0780 && sclk_run < 16'h1e00) else $error("sync hold length wrong");
  chk_release_ready: assert property (rdy_end |-> rel_cnt == 16'h0000 ||
    rel_cnt > 16'h08fc) else $error("ready too early after release");
  chk_release_bound: assert property (rel_cnt != 16'h0000 |-> rel_cnt < 16'h0960)
    else $error("no ready after release");
endmodule

// *** test/adc_result_readout_sync_tb.sv ***
// self-checking bench joining the converter end and the host end
`timescale 1ns/1ps
module adc_result_readout_sync_tb;
  import adc_readout_pkg::*;
  // ==========================================================
  // steady-input table and bench signals
  typedef struct {
    logic [3:0] pat;
    logic [23:0] exp;
  } row_s;
  // ones density 0, 1/4, 1/2, 3/4, 1: -full, -half, zero, +half, +full (clipped)
  row_s rows [5] = '{'{4'h0, 24'h800000}, '{4'h1, 24'hc00000}, '{4'h5, 24'h000000},
    '{4'h7, 24'h400000}, '{4'hf, 24'h7fffff}};
  logic i_clk_sys;
  logic i_rst_b;
  logic i_mod_bit;
  logic i_sync_req;
  logic o_mod_in_reset;
  logic o_result_valid;
  logic o_data_valid;
  logic [23:0] o_data;
  logic o_sync_busy;
  logic [3:0] pat;
  int cyc = 0;
  int n;
  int err_count = 0;
  int checks_done = 0;
  // ==========================================================
  // design, link and checker
  adc_readout_if adc_readout_if_inst ();
  adc_readout_device adc_readout_device_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_ce(1'b1), .i_mod_bit(i_mod_bit), .link(adc_readout_if_inst),
    .o_mod_in_reset(o_mod_in_reset), .o_result_valid(o_result_valid));
  adc_readout_host adc_readout_host_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_ce(1'b1), .i_sync_req(i_sync_req), .o_data_valid(o_data_valid), .o_data(o_data),
    .o_sync_busy(o_sync_busy), .link(adc_readout_if_inst));
  adc_readout_chk adc_readout_chk_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_serial_clk(adc_readout_if_inst.serial_clk),
    .i_shared_ready_data_pin(adc_readout_if_inst.shared_ready_data_pin));
  // clock, 50 ns period
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // one bit held six clocks, so every modulator sample sees it whatever the phase
  always @(negedge i_clk_sys) begin
    cyc <= cyc + 1;
    i_mod_bit <= pat[(cyc / 6) % 4];
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    err_count++;
    $display("mismatch run_time expected done seen timeout");
    stop_test();
  end
  // ==========================================================
  // tasks
  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_valid(input int limit);
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (o_data_valid !== 1'b1 && n < limit);
    if (o_data_valid !== 1'b1) begin
      check("data_valid", 24'h000001, 24'h000000);
      stop_test();
    end
  endtask
  task automatic stop_test();
    $display("counts: %0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    i_rst_b = 1'b0;
    i_mod_bit = 1'b0;
    i_sync_req = 1'b0;
    pat = 4'h0;
    repeat (6) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    // steady inputs; the seventh word after a change is past any unaligned step
    foreach (rows[i]) begin
      pat = rows[i].pat;
      repeat (7) wait_valid(3000);
      check("word", rows[i].exp, o_data);
      check("result_valid", 24'h000001, {23'h0, o_result_valid});
      $display("test row %0d done", i);
    end
    // reset in mid-run: pin high, clock low, first word only once valid
    @(negedge i_clk_sys);
    i_rst_b = 1'b0;
    repeat (6) @(negedge i_clk_sys);
    check("pin_in_reset", 24'h000001, {23'h0, adc_readout_if_inst.shared_ready_data_pin});
    check("sclk_in_reset", 24'h000000, {23'h0, adc_readout_if_inst.serial_clk});
    i_rst_b = 1'b1;
    wait_valid(3000);
    check("first_word_delay", 24'h000001, 24'(n > 2304 && n < 2688));
    check("first_word", 24'h7fffff, o_data);
    $display("test reset done");
    // synchronisation hold requested right after a word was read
    pat = 4'h5;
    wait_valid(400);
    @(negedge i_clk_sys);
    i_sync_req = 1'b1;
    n = 0;
    while (o_sync_busy !== 1'b1 && n < 400) begin
      @(negedge i_clk_sys);
      n++;
    end
    i_sync_req = 1'b0;
    check("sync_busy", 24'h000001, {23'h0, o_sync_busy});
    n = 0;
    while (o_mod_in_reset !== 1'b1 && n < 2400) begin
      @(negedge i_clk_sys);
      n++;
    end
    check("mod_in_reset", 24'h000001, {23'h0, o_mod_in_reset});
    n = 0;
    while (adc_readout_if_inst.serial_clk === 1'b1 && n < 8000) begin
      @(negedge i_clk_sys);
      n++;
    end
    repeat (3) @(negedge i_clk_sys);
    check("mod_released", 24'h000000, {23'h0, o_mod_in_reset});
    wait_valid(3000);
    check("sync_first_delay", 24'h000001, 24'(n > 2300 && n < 2688));
    check("sync_first_word", 24'h000000, o_data);
    $display("test sync done");
    stop_test();
  end
endmodule
